/* File: rtl/txpa_pkg.sv */
// txpa_pkg: constants for the transmit input clocking and phase align block
// assumes a 25 MHz ref_clk and an AXI4-Lite master with 32-bit data
package txpa_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] TXPA_OFF_CTRL  = 8'h00;
  localparam logic [7:0] TXPA_OFF_STAT  = 8'h04;
  localparam logic [7:0] TXPA_OFF_MASK  = 8'h08;
  localparam logic [7:0] TXPA_OFF_STATE = 8'h0C;
  localparam logic [7:0] TXPA_OFF_CHAR  = 8'h10;
  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int TXPA_CTRL_SEL   = 0;
  localparam int TXPA_CTRL_HALF  = 1;
  localparam int TXPA_CTRL_RATE  = 2;
  localparam int TXPA_CTRL_PAB   = 3;
  localparam int TXPA_CTRL_WSYNC = 4;
  localparam logic TXPA_SEL_RST  = 1'b0;
  localparam logic TXPA_HALF_RST = 1'b0;
  localparam logic TXPA_RATE_RST = 1'b0;
  localparam logic TXPA_PAB_RST  = 1'b1;
  // ----------------------------------------------------------------
  // status and mask fields
  // ----------------------------------------------------------------
  localparam int TXPA_EV_OVF  = 0;
  localparam int TXPA_EV_UNF  = 1;
  localparam int TXPA_EV_LOSS = 2;
  localparam int TXPA_EV_W    = 3;
  localparam logic [2:0] TXPA_MASK_RST = 3'h0;
  // state register: bit0 error out, bit1 reference present, bits 4:2 fill
  localparam int TXPA_ST_ERR  = 0;
  localparam int TXPA_ST_REF  = 1;
  localparam int TXPA_ST_FILL = 2;
  // ----------------------------------------------------------------
  // phase align buffer and timing
  // ----------------------------------------------------------------
  localparam int TXPA_CHAR_W = 10;
  localparam int TXPA_DEPTH  = 4;
  localparam logic [2:0] TXPA_DEPTH_C  = 3'h4;
  localparam logic [2:0] TXPA_CENTRE   = 3'h2;
  localparam int TXPA_CLK_NS      = 40;
  localparam int TXPA_REF_LOSS_NS = 640;
  localparam int TXPA_REF_LOSS_CYC = (TXPA_REF_LOSS_NS + TXPA_CLK_NS - 1) / TXPA_CLK_NS;
  localparam logic [5:0] TXPA_LOSS_LIM = 6'(TXPA_REF_LOSS_CYC);
  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] TXPA_RESP_OK  = 2'h0;
  localparam logic [1:0] TXPA_RESP_ERR = 2'h2;
endpackage : txpa_pkg

/* File: rtl/txpa_top.sv */
// txpa_top: transmit input clocking, phase align buffer and error output
// pins are asynchronous to ref_clk and pass two flip-flops before use
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module txpa_top
  import txpa_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        channel_ref_clock,
  input  wire logic        host_tx_input_clock,
  input  wire logic [7:0]  tx_char_data_in,
  input  wire logic [1:0]  tx_char_control_in,
  output logic             tx_path_error_out,
  output logic             tx_clock_output,
  output logic [9:0]       tx_char_out,
  output logic             tx_char_valid,
  output logic             irq,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  typedef struct packed {
    logic                         ref_m;
    logic                         ref_q;
    logic                         ref_p;
    logic                         hck_m;
    logic                         hck_q;
    logic                         hck_p;
    logic [TXPA_CHAR_W-1:0]       dat_m;
    logic [TXPA_CHAR_W-1:0]       dat_q;
    logic [5:0]                   loss_cnt;
    logic                         ref_abs;
    logic [5:0]                   hp_cnt;
    logic [5:0]                   hp_len;
    logic                         tx_clk;
    logic [TXPA_DEPTH-1:0][TXPA_CHAR_W-1:0] mem;
    logic [2:0]                   wp;
    logic [2:0]                   rp;
    logic                         buf_err;
    logic                         err_out;
    logic [TXPA_CHAR_W-1:0]       ch_out;
    logic                         ch_vld;
    logic                         sel;
    logic                         half;
    logic                         rate;
    logic                         pab;
    logic [TXPA_EV_W-1:0]         sts;
    logic [TXPA_EV_W-1:0]         msk;
    logic                         irq;
    logic                         aw_rdy;
    logic                         w_rdy;
    logic                         aw_ok;
    logic                         w_ok;
    logic [7:0]                   awa;
    logic [31:0]                  wd;
    logic [3:0]                   ws;
    logic                         bvalid;
    logic [1:0]                   bresp;
    logic                         ar_rdy;
    logic                         rvalid;
    logic [31:0]                  rdata;
    logic [1:0]                   rresp;
  } txpa_state_t;

  txpa_state_t r;
  txpa_state_t n;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic txpa_mapped(input logic [7:0] a);
    txpa_mapped = (a == TXPA_OFF_CTRL) || (a == TXPA_OFF_STAT) ||
                  (a == TXPA_OFF_MASK) || (a == TXPA_OFF_STATE) ||
                  (a == TXPA_OFF_CHAR);
  endfunction : txpa_mapped

  logic       ref_rise;
  logic       ref_edge;
  logic       char_en;
  logic       host_wr;
  logic [2:0] fill;
  logic [TXPA_EV_W-1:0] ev;
  logic [TXPA_EV_W-1:0] clr;
  logic       wr_go;
  logic       rd_go;

  always_comb begin
    n        = r;
    ev       = '0;
    clr      = '0;
    // --------------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------------
    n.ref_m  = channel_ref_clock;
    n.ref_q  = r.ref_m;
    n.ref_p  = r.ref_q;
    n.hck_m  = host_tx_input_clock;
    n.hck_q  = r.hck_m;
    n.hck_p  = r.hck_q;
    n.dat_m  = {tx_char_control_in, tx_char_data_in};
    n.dat_q  = r.dat_m;
    ref_rise = r.ref_q & ~r.ref_p;
    ref_edge = r.ref_q ^ r.ref_p;
    // character clock from the reference: rising, or both edges at half rate
    char_en  = r.half ? ref_edge : ref_rise;
    host_wr  = ~r.sel & r.hck_q & ~r.hck_p;
    fill     = 3'(r.wp - r.rp);

    // --------------------------------------------------------------
    // reference loss detection
    // --------------------------------------------------------------
    if (ref_edge) begin
      n.loss_cnt = '0;
    end else if (r.loss_cnt != TXPA_LOSS_LIM) begin
      n.loss_cnt = 6'(r.loss_cnt + 6'h01);
    end
    n.ref_abs = (n.loss_cnt == TXPA_LOSS_LIM);
    if (n.ref_abs && !r.ref_abs) begin
      ev[TXPA_EV_LOSS] = 1'b1;
    end

    // --------------------------------------------------------------
    // transmit clock output
    // --------------------------------------------------------------
    if (ref_edge) begin
      n.hp_cnt = '0;
      n.hp_len = 6'(r.hp_cnt + 6'h01);
    end else if (r.hp_cnt != 6'h3F) begin
      n.hp_cnt = 6'(r.hp_cnt + 6'h01);
    end
    if (!r.rate) begin
      n.tx_clk = r.ref_q;
    end else if (ref_edge) begin
      n.tx_clk = ~r.tx_clk;
    end else if (6'(r.hp_cnt + 6'h01) == (r.hp_len >> 1)) begin
      n.tx_clk = ~r.tx_clk;
    end

    // --------------------------------------------------------------
    // phase align buffer and character capture
    // --------------------------------------------------------------
    n.ch_vld = 1'b0;
    if (host_wr) begin
      if (fill == TXPA_DEPTH_C) begin
        ev[TXPA_EV_OVF] = 1'b1;
        n.buf_err = 1'b1;
      end else begin
        n.mem[r.wp[1:0]] = r.dat_q;
        n.wp = 3'(r.wp + 3'h1);
      end
    end
    if (char_en) begin
      if (r.sel) begin
        n.ch_out = r.dat_q;
        n.ch_vld = 1'b1;
      end else if (fill == 3'h0) begin
        ev[TXPA_EV_UNF] = 1'b1;
        n.buf_err = 1'b1;
      end else begin
        n.ch_out = r.mem[r.rp[1:0]];
        n.ch_vld = 1'b1;
        n.rp = 3'(r.rp + 3'h1);
      end
    end

    // --------------------------------------------------------------
    // register bus: write channel
    // --------------------------------------------------------------
    if (s_axi_awvalid && r.aw_rdy) begin
      n.aw_ok  = 1'b1;
      n.aw_rdy = 1'b0;
      n.awa    = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.w_rdy) begin
      n.w_ok  = 1'b1;
      n.w_rdy = 1'b0;
      n.wd    = s_axi_wdata;
      n.ws    = s_axi_wstrb;
    end
    wr_go = r.aw_ok && r.w_ok && !r.bvalid;
    if (wr_go) begin
      n.aw_ok  = 1'b0;
      n.w_ok   = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = txpa_mapped(r.awa) ? TXPA_RESP_OK : TXPA_RESP_ERR;
      if (r.ws[0] && r.awa == TXPA_OFF_CTRL) begin
        n.sel  = r.wd[TXPA_CTRL_SEL];
        n.half = r.wd[TXPA_CTRL_HALF];
        n.rate = r.wd[TXPA_CTRL_RATE];
        n.pab  = r.wd[TXPA_CTRL_PAB];
        if (!r.wd[TXPA_CTRL_PAB]) begin
          // recentre: read side keeps running, write side jumps ahead
          n.wp      = 3'(n.rp + TXPA_CENTRE);
          n.buf_err = 1'b0;
        end
        // with pab set, a slip in the same cycle as the word sync keeps the error set
        if (r.wd[TXPA_CTRL_WSYNC] && !ev[TXPA_EV_OVF] && !ev[TXPA_EV_UNF]) begin
          n.buf_err = 1'b0;
        end
      end
      if (r.ws[0] && r.awa == TXPA_OFF_MASK) begin
        n.msk = r.wd[TXPA_EV_W-1:0];
      end
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
      n.aw_rdy = 1'b1;
      n.w_rdy  = 1'b1;
    end

    // --------------------------------------------------------------
    // register bus: read channel
    // --------------------------------------------------------------
    rd_go = s_axi_arvalid && r.ar_rdy;
    if (rd_go) begin
      n.ar_rdy = 1'b0;
      n.rvalid = 1'b1;
      n.rresp  = txpa_mapped(s_axi_araddr) ? TXPA_RESP_OK : TXPA_RESP_ERR;
      n.rdata  = '0;
      case (s_axi_araddr)
        TXPA_OFF_CTRL: begin
          n.rdata[TXPA_CTRL_SEL]  = r.sel;
          n.rdata[TXPA_CTRL_HALF] = r.half;
          n.rdata[TXPA_CTRL_RATE] = r.rate;
          n.rdata[TXPA_CTRL_PAB]  = r.pab;
        end
        TXPA_OFF_STAT: begin
          n.rdata[TXPA_EV_W-1:0] = r.sts;
          clr = '1;
        end
        TXPA_OFF_MASK: begin
          n.rdata[TXPA_EV_W-1:0] = r.msk;
        end
        TXPA_OFF_STATE: begin
          n.rdata[TXPA_ST_ERR]                = r.err_out;
          n.rdata[TXPA_ST_REF]                = ~r.ref_abs;
          n.rdata[TXPA_ST_FILL+2:TXPA_ST_FILL] = fill;
        end
        TXPA_OFF_CHAR: begin
          n.rdata[TXPA_CHAR_W-1:0] = r.ch_out;
        end
        default: begin
          n.rdata = '0;
        end
      endcase
    end
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
      n.ar_rdy = 1'b1;
    end

    // --------------------------------------------------------------
    // events, interrupt and error output
    // --------------------------------------------------------------
    // a new event wins over a read clear in the same cycle
    n.sts = (r.sts & ~clr) | ev;
    n.irq = |(n.sts & n.msk);
    // error output moves on character edges, or at once on reference loss
    if (char_en || n.ref_abs) begin
      n.err_out = n.buf_err | n.ref_abs;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r          <= '0;
      r.loss_cnt <= TXPA_LOSS_LIM;
      r.ref_abs  <= 1'b1;
      r.err_out  <= 1'b1;
      r.wp       <= TXPA_CENTRE;
      r.sel      <= TXPA_SEL_RST;
      r.half     <= TXPA_HALF_RST;
      r.rate     <= TXPA_RATE_RST;
      r.pab      <= TXPA_PAB_RST;
      r.msk      <= TXPA_MASK_RST;
      r.bresp    <= TXPA_RESP_OK;
      r.rresp    <= TXPA_RESP_OK;
      // bus ready to take a request straight out of reset
      r.aw_rdy   <= 1'b1;
      r.w_rdy    <= 1'b1;
      r.ar_rdy   <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign tx_path_error_out = r.err_out;
  assign tx_clock_output   = r.tx_clk;
  assign tx_char_out       = r.ch_out;
  assign tx_char_valid     = r.ch_vld;
  assign irq               = r.irq;
  assign s_axi_awready     = r.aw_rdy;
  assign s_axi_wready      = r.w_rdy;
  assign s_axi_bresp       = r.bresp;
  assign s_axi_bvalid      = r.bvalid;
  assign s_axi_arready     = r.ar_rdy;
  assign s_axi_rdata       = r.rdata;
  assign s_axi_rresp       = r.rresp;
  assign s_axi_rvalid      = r.rvalid;

endmodule : txpa_top

/* File: verification/txpa_host_model.sv */
// txpa_host_model: host logic driving the parallel character pins
// assumes the bench supplies the next character and run and drift controls
`timescale 1ns/1ps
module txpa_host_model (
  input  wire logic       run,
  input  wire logic       slow,
  input  wire logic [9:0] next_char,
  output logic            host_tx_input_clock,
  output logic [7:0]      tx_char_data_in,
  output logic [1:0]      tx_char_control_in
);
  initial begin
    host_tx_input_clock = 1'b0;
    {tx_char_control_in, tx_char_data_in} = 10'h000;
    #53;
    forever begin
      if (run) begin
        // same period as the reference, fixed phase offset
        #160 host_tx_input_clock = 1'b1;
        // slow stretches the period past the drift window
        #(slow ? 200 : 160) host_tx_input_clock = 1'b0;
        // data moves away from the capturing edge
        {tx_char_control_in, tx_char_data_in} = next_char;
      end else begin
        // clock parked low, data still presented for reference-clock capture
        #160 {tx_char_control_in, tx_char_data_in} = next_char;
      end
    end
  end
endmodule : txpa_host_model

/* File: verification/txpa_top_sva.sv */
// txpa_top_sva: port level checks of txpa_top
// assumes one ref_clk domain; bound by name below the module
`timescale 1ns/1ps
module txpa_top_sva
  import txpa_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        channel_ref_clock,
  input wire logic        tx_path_error_out,
  input wire logic [9:0]  tx_char_out,
  input wire logic        tx_char_valid,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // ----------------------------------------------------------------
  // cycles since the reference pin last moved
  // ----------------------------------------------------------------
  logic       ref_q_r;
  logic [5:0] still_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ref_q_r <= 1'b0;
      still_r <= 6'h00;
    end else begin
      ref_q_r <= channel_ref_clock;
      still_r <= (ref_q_r != channel_ref_clock) ? 6'h00 : still_r + {5'h00, ~&still_r};
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_ref_loss; (still_r >= 6'h18) |-> tx_path_error_out; endproperty
  a_ref_loss: assert property (p_ref_loss) else $error("error out low, no reference");
  property p_valid_pulse; tx_char_valid |=> !tx_char_valid; endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("valid wider than one cycle");
  property p_char_hold; $changed(tx_char_out) |-> tx_char_valid; endproperty
  a_char_hold: assert property (p_char_hold) else $error("char changed without valid");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response dropped");
  property p_b_time;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_b_time: assert property (p_b_time) else $error("write response late");
  property p_r_time; s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid; endproperty
  a_r_time: assert property (p_r_time) else $error("read response late");
  property p_err_rdata; s_axi_rvalid && s_axi_rresp == TXPA_RESP_ERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_err_rdata: assert property (p_err_rdata) else $error("refused read returned data");
  property p_one_wr; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_one_wr: assert property (p_one_wr) else $error("second write accepted early");
  c_valid: cover property (tx_char_valid);
  c_err_rise: cover property ($rose(tx_path_error_out));
  c_bad_read: cover property (s_axi_rvalid && s_axi_rresp == TXPA_RESP_ERR);
endmodule : txpa_top_sva

bind txpa_top txpa_top_sva i_txpa_top_sva (
  .ref_clk(ref_clk), .rst(rst), .channel_ref_clock(channel_ref_clock),
  .tx_path_error_out(tx_path_error_out), .tx_char_out(tx_char_out),
  .tx_char_valid(tx_char_valid), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

/* File: verification/txpa_top_tb.sv */
// txpa_top_tb: self-checking bench of txpa_top with a host model
// assumes txpa_pkg register map and an AXI4-Lite slave on the top
`timescale 1ns/1ps
module txpa_top_tb
  import txpa_pkg::*;
;
  logic        ref_clk, rst, channel_ref_clock, ref_run, run, slow;
  logic        host_tx_input_clock, tx_path_error_out, tx_clock_output, tx_char_valid, irq;
  logic [7:0]  tx_char_data_in, s_axi_awaddr, s_axi_araddr;
  logic [1:0]  tx_char_control_in, s_axi_bresp, s_axi_rresp;
  logic [9:0]  tx_char_out, next_char;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [15:0] lfsr_r;
  int          miscompares = 0, total_checks = 0, cyc = 0;

  txpa_top i_txpa_top (.ref_clk(ref_clk), .rst(rst), .channel_ref_clock(channel_ref_clock),
    .host_tx_input_clock(host_tx_input_clock), .tx_char_data_in(tx_char_data_in),
    .tx_char_control_in(tx_char_control_in), .tx_path_error_out(tx_path_error_out),
    .tx_clock_output(tx_clock_output), .tx_char_out(tx_char_out), .irq(irq),
    .tx_char_valid(tx_char_valid), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  txpa_host_model i_txpa_host_model (.run(run), .slow(slow), .next_char(next_char),
    .host_tx_input_clock(host_tx_input_clock), .tx_char_data_in(tx_char_data_in),
    .tx_char_control_in(tx_char_control_in));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    channel_ref_clock = 1'b0;
    #7;
    forever #160 if (ref_run) channel_ref_clock = ~channel_ref_clock;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask : axi_rd
  task automatic meas(input logic h, input logic r);
    int   nv;
    int   nt;
    logic pc;
    axi_wr(TXPA_OFF_CTRL, {27'h0, 2'b01, r, h, 1'b1}, TXPA_RESP_OK);
    nv = 0;
    nt = 0;
    repeat (16) @(posedge ref_clk);
    pc = tx_clock_output;
    repeat (80) begin
      @(posedge ref_clk);
      nv += int'(tx_char_valid === 1'b1);
      nt += int'(tx_clock_output !== pc);
      pc = tx_clock_output;
    end
    chk("valid_count", 32'h1, 32'(nv >= (h ? 19 : 9) && nv <= (h ? 21 : 11)));
    if (!h) chk("clk_toggles", 32'h1, 32'(nt >= (r ? 38 : 18) && nt <= (r ? 42 : 22)));
  endtask : meas
  task automatic cap();
    next_char <= lfsr_r[9:0];
    lfsr_r <= lfsr_next(lfsr_r);
    repeat (48) @(posedge ref_clk);
    do @(posedge ref_clk); while (tx_char_valid !== 1'b1);
    chk("char", 32'(next_char), 32'(tx_char_out));
  endtask : cap
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, ref_run, run, slow, next_char, lfsr_r} = {1'b1, 1'b1, 2'b00, 10'h000, 16'h0004};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (40) @(posedge ref_clk);
    axi_rd(TXPA_OFF_CTRL, rd, TXPA_RESP_OK);
    chk("ctrl_reset", 32'(TXPA_PAB_RST) << TXPA_CTRL_PAB, rd);
    axi_rd(TXPA_OFF_MASK, rd, TXPA_RESP_OK);
    chk("mask_reset", 32'(TXPA_MASK_RST), rd);
    axi_rd(8'h20, rd, TXPA_RESP_ERR);
    axi_wr(8'h20, 32'hFFFFFFFF, TXPA_RESP_ERR);
    axi_rd(TXPA_OFF_STATE, rd, TXPA_RESP_OK);
    chk("ref_present", 32'h1, 32'(rd[TXPA_ST_REF]));
    for (int i = 0; i < 3; i++) meas(i == 1, i == 2);
    repeat (4) cap();
    axi_rd(TXPA_OFF_CHAR, rd, TXPA_RESP_OK);
    chk("char_reg", 32'(next_char), rd);
    run <= 1'b1;
    // let the host clock run before the buffer is recentred
    repeat (20) @(posedge ref_clk);
    axi_wr(TXPA_OFF_CTRL, 32'h0, TXPA_RESP_OK);
    axi_wr(TXPA_OFF_CTRL, 32'h8, TXPA_RESP_OK);
    repeat (60) @(posedge ref_clk);
    chk("err_init", 32'h0, 32'(tx_path_error_out));
    repeat (4) cap();
    axi_wr(TXPA_OFF_MASK, 32'h3, TXPA_RESP_OK);
    for (int k = 0; k < 2; k++) begin
      slow <= 1'b1;
      repeat (400) @(posedge ref_clk);
      slow <= 1'b0;
      repeat (40) @(posedge ref_clk);
      chk("slip_err", 32'h1, 32'(tx_path_error_out));
      chk("slip_irq", 32'h1, 32'(irq));
      axi_rd(TXPA_OFF_STAT, rd, TXPA_RESP_OK);
      chk("slip_stat", 32'h1, 32'(rd[1:0] != 2'h0));
      if (k == 0) axi_wr(TXPA_OFF_CTRL, 32'h0, TXPA_RESP_OK);
      axi_wr(TXPA_OFF_CTRL, (k == 0) ? 32'h8 : 32'h18, TXPA_RESP_OK);
      repeat (12) @(posedge ref_clk);
      chk("slip_clear", 32'h0, 32'(tx_path_error_out));
    end
    axi_rd(TXPA_OFF_STAT, rd, TXPA_RESP_OK);
    axi_rd(TXPA_OFF_STAT, rd, TXPA_RESP_OK);
    chk("stat_cleared", 32'h0, rd);
    chk("irq_low", 32'h0, 32'(irq));
    axi_wr(TXPA_OFF_MASK, 32'h4, TXPA_RESP_OK);
    ref_run <= 1'b0;
    repeat (40) @(posedge ref_clk);
    chk("loss_err", 32'h1, 32'(tx_path_error_out));
    chk("loss_irq", 32'h1, 32'(irq));
    axi_rd(TXPA_OFF_STAT, rd, TXPA_RESP_OK);
    chk("loss_stat", 32'h1, 32'(rd[TXPA_EV_LOSS]));
    results();
  end
endmodule : txpa_top_tb
